// File: src/serial_comm_unit_regs.svh
/*
  register offsets, field positions, reset values and timing figures of the
  serial communication unit.
  assumes byte addresses on a 32-bit bus, one aligned word per register.
*/
`ifndef SERIAL_COMM_UNIT_REGS_SVH
`define SERIAL_COMM_UNIT_REGS_SVH

// byte offsets
`define OFS_MODE 8'h00
`define OFS_BITRATE 8'h04
`define OFS_CONTROL 8'h08
`define OFS_TXDATA 8'h0c
`define OFS_STATUS 8'h10
`define OFS_RXDATA 8'h14

// serial_mode_reg fields
`define MODE_CLOCKED 0
`define MODE_SEVEN 1
`define MODE_TWO_STOP 2
`define MODE_MP 3

// serial_control_reg fields
`define CTL_TE 0
`define CTL_RE 1
`define CTL_TIE 2
`define CTL_RIE 3
`define CTL_TX_END_IRQ_ENABLE 4
`define CTL_CKE_LO 5
`define CTL_CKE_HI 6
`define CTL_MP_WAIT 7

// serial_status_reg fields
`define ST_TX_EMPTY_FLAG 7
`define ST_RX_FULL_FLAG 6
`define ST_OVERRUN_FLAG 5
`define ST_FER 4
`define ST_PER 3
`define ST_TX_END_FLAG 2
`define ST_MPB 1
`define ST_TX_MULTIPROC_FLAG 0

// reset values
`define MODE_RST 8'h00
`define CONTROL_RST 8'h00
`define BITRATE_RST 8'h05

// oversampling of the asynchronous formats
`define OVS_LAST 4'hf
`define OVS_MID 4'h7

`endif

// File: src/serial_comm_unit_pkg.sv
/*
  types of the serial communication unit.
  assumes nothing beyond the register header.
*/
package serial_comm_unit_pkg;
  typedef enum logic [1:0] {
    arx_idle,
    arx_start,
    arx_data,
    arx_stop
  } arx_state_e;
endpackage : serial_comm_unit_pkg

// File: src/bit_rate_divider.sv
/*
  divider making one-cycle enable pulses every div+1 clock cycles.
  assumes div is quasi-static while en is high.
*/
`timescale 1ns/10ps
`default_nettype none
module bit_rate_divider (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic en,
  input wire logic [7:0] div,
  // pulse
  output logic tick
);
  logic [7:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!en) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : bit_rate_divider
`default_nettype wire

// File: src/pin_sync.sv
/*
  two-flop synchronisers for the serial pins.
  assumes the inputs are asynchronous to hclk; outputs reset high (idle line).
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic [1:0] pin_in,
  // synchronised
  output logic [1:0] pin_sync_out
);
  logic [1:0] meta_r;

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_r[i] <= 1'b1;
        pin_sync_out[i] <= 1'b1;
      end else begin
        meta_r[i] <= pin_in[i];
        pin_sync_out[i] <= meta_r[i];
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// File: src/serial_comm_unit.sv
/*
  serial communication unit: asynchronous and multiprocessor framing,
  clocked mode with internal or external serial clock, ahb-lite registers.
  assumes a single ahb-lite master, whole-word accesses, and serial pins
  asynchronous to hclk.
*/
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "serial_comm_unit_regs.svh"
// Operation
// - mp frame: start, data lsb first, mp, stops
// - clearing empty flag loads shifter, sets flag
// - mark ones after stop bits
// - check empty flag at stop bit
// - clocked tx and rx share clock, double-buffered
// - drive on falling, capture on rising edge
// - clocked bits 0..7, line holds last
// - clocked characters always eight bits
// - clock source from mode and enable bits
// - internal clock: eight pulses, idle high
// - tx disable sets empty; rx disable keeps flags
// - clocked: check empty flag at bit 7
// - error flags block full flag and transfers
// - clocked: copy character, set full if empty
// - no transfer until errors cleared
// - full and overrun interrupt requests
// - overrun when full, data not copied
// - mp receiver discards until mp bit set
module serial_comm_unit (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial pins
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  // interrupt requests
  output logic tx_empty_irq,
  output logic tx_end_irq,
  output logic rx_full_irq,
  output logic rx_error_irq
);
  logic [7:0] mode_r, ctl_r, div_r, thr_r, rdr_r;
  logic tx_empty_flag_r, tx_end_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r, mpb_r, tx_multiproc_flag_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic acc;
  logic [7:0] rd_mux;
  logic wr_mode, wr_div, wr_ctl, wr_thr, wr_st;
  logic cm, te, re, err, ext_clk;
  logic [1:0] pins;
  logic s_rx, s_sck, sck_prev_r, sck_rise, sck_fall;
  logic div_tick, tick16, fall_ev, rise_ev;
  logic sck_r, run;
  logic [2:0] icnt_r;
  logic tx_act_r, next_ld_r;
  logic [11:0] tsr_r, frame;
  logic [3:0] left_r, nbits, tovs_r;
  logic [2:0] tcnt_r;
  logic idle_load;
  serial_comm_unit_pkg::arx_state_e rst_r;
  logic [3:0] rovs_r, rcnt_r, rn;
  logic [8:0] rbuf_r, al;
  logic [7:0] rdat;
  logic rmp;

  // ahb-lite address phase, zero wait states, always okay
  assign acc = hsel & hready & htrans[1];
  assign te = ctl_r[`CTL_TE];
  assign re = ctl_r[`CTL_RE];
  assign cm = mode_r[`MODE_CLOCKED];
  assign ext_clk = ctl_r[`CTL_CKE_HI];
  assign err = overrun_flag_r | fer_r | per_r;

  always_comb begin
    if (haddr[7:0] == `OFS_MODE) begin
      rd_mux = mode_r;
    end else if (haddr[7:0] == `OFS_BITRATE) begin
      rd_mux = div_r;
    end else if (haddr[7:0] == `OFS_CONTROL) begin
      rd_mux = ctl_r;
    end else if (haddr[7:0] == `OFS_TXDATA) begin
      rd_mux = thr_r;
    end else if (haddr[7:0] == `OFS_STATUS) begin
      rd_mux = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r, tx_end_flag_r, mpb_r, tx_multiproc_flag_r};
    end else if (haddr[7:0] == `OFS_RXDATA) begin
      rd_mux = rdr_r;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      wr_pend_r <= acc & hwrite & (hsize == 3'h2) & (haddr[31:8] == 24'h00_0000);
      wr_addr_r <= haddr[7:0];
      hrdata <= (acc & !hwrite & (haddr[31:8] == 24'h00_0000)) ? {24'h00_0000, rd_mux} :
        32'h0000_0000;
    end
  end

  assign wr_mode = wr_pend_r & (wr_addr_r == `OFS_MODE);
  assign wr_div = wr_pend_r & (wr_addr_r == `OFS_BITRATE);
  assign wr_ctl = wr_pend_r & (wr_addr_r == `OFS_CONTROL);
  assign wr_thr = wr_pend_r & (wr_addr_r == `OFS_TXDATA);
  assign wr_st = wr_pend_r & (wr_addr_r == `OFS_STATUS);

  // software-owned registers; mode changes are safe only with te and re off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= `MODE_RST;
      div_r <= `BITRATE_RST;
      thr_r <= 8'h00;
      tx_multiproc_flag_r <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_r <= {4'h0, hwdata[3:0]};
      end
      if (wr_div) begin
        div_r <= hwdata[7:0];
      end
      if (wr_thr) begin
        thr_r <= hwdata[7:0];
      end
      if (wr_st) begin
        tx_multiproc_flag_r <= hwdata[`ST_TX_MULTIPROC_FLAG];
      end
    end
  end

  // mp wait bit: software sets it, an identifier character clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= `CONTROL_RST;
    end else if (rst_r == serial_comm_unit_pkg::arx_stop && tick16 && rovs_r == `OVS_LAST &&
                 mode_r[`MODE_MP] && rmp) begin
      ctl_r <= wr_ctl ? {1'b0, hwdata[6:0]} : {1'b0, ctl_r[6:0]};
    end else if (wr_ctl) begin
      ctl_r <= hwdata[7:0];
    end
  end

  // pins and clock events
  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({sck_in, rxd_in}),
    .pin_sync_out(pins)
  );
  assign s_rx = pins[0];
  assign s_sck = pins[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= s_sck;
    end
  end
  assign sck_rise = s_sck & !sck_prev_r;
  assign sck_fall = !s_sck & sck_prev_r;

  bit_rate_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(te | re),
    .div(div_r),
    .tick(div_tick)
  );
  assign tick16 = ext_clk ? sck_rise : div_tick;

  // internal serial clock: whole characters of eight pulses, idle high
  assign run = tx_act_r | (re & !err);
  assign fall_ev = ext_clk ? sck_fall : (div_tick & sck_r & ((icnt_r != 3'h0) | run));
  assign rise_ev = ext_clk ? sck_rise : (div_tick & !sck_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_r <= 1'b1;
      icnt_r <= 3'h0;
    end else if (!cm || ext_clk) begin
      sck_r <= 1'b1;
      icnt_r <= 3'h0;
    end else if (fall_ev) begin
      sck_r <= 1'b0;
    end else if (rise_ev) begin
      sck_r <= 1'b1;
      icnt_r <= icnt_r + 3'h1;
    end
  end

  // asynchronous frame, lsb first, optional mp bit, ones fill the rest
  always_comb begin
    frame = 12'hfff;
    frame[0] = 1'b0;
    if (mode_r[`MODE_SEVEN]) begin
      frame[7:1] = thr_r[6:0];
      frame[8] = mode_r[`MODE_MP] ? tx_multiproc_flag_r : 1'b1;
    end else begin
      frame[8:1] = thr_r;
      frame[9] = mode_r[`MODE_MP] ? tx_multiproc_flag_r : 1'b1;
    end
    nbits = (mode_r[`MODE_SEVEN] ? 4'h8 : 4'h9) + {3'h0, mode_r[`MODE_MP]} +
      (mode_r[`MODE_TWO_STOP] ? 4'h2 : 4'h1);
  end

  // a load needs the empty flag low first: software clears it, a load sets it again
  assign idle_load = te && !tx_act_r && !tx_empty_flag_r && !(cm && err);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_act_r <= 1'b0;
      next_ld_r <= 1'b0;
      tsr_r <= 12'hfff;
      left_r <= 4'h0;
      tovs_r <= 4'h0;
      tcnt_r <= 3'h0;
      tx_empty_flag_r <= 1'b1;
      tx_end_flag_r <= 1'b1;
      txd_out <= 1'b1;
    end else if (!te) begin
      tx_act_r <= 1'b0;
      next_ld_r <= 1'b0;
      tsr_r <= 12'hfff;
      tx_empty_flag_r <= 1'b1;
      tx_end_flag_r <= 1'b1;
      txd_out <= 1'b1;
    end else begin
      if (wr_st && !hwdata[`ST_TX_EMPTY_FLAG]) begin
        tx_empty_flag_r <= 1'b0;
      end
      if (wr_st && !hwdata[`ST_TX_END_FLAG]) begin
        tx_end_flag_r <= 1'b0;
      end
      if (idle_load) begin
        tx_act_r <= 1'b1;
        tx_empty_flag_r <= 1'b1;
        tx_end_flag_r <= 1'b0;
        tovs_r <= 4'h0;
        tcnt_r <= 3'h0;
        left_r <= nbits;
        tsr_r <= cm ? {4'hf, thr_r} : frame;
        if (!cm) begin
          txd_out <= 1'b0;
        end
      end else if (tx_act_r && cm && fall_ev) begin
        txd_out <= tsr_r[0];
        tsr_r <= {1'b1, tsr_r[11:1]};
        tcnt_r <= tcnt_r + 3'h1;
        if (tcnt_r == 3'h7) begin
          if (!tx_empty_flag_r && !err) begin
            tsr_r <= {4'hf, thr_r};
            tx_empty_flag_r <= 1'b1;
          end else begin
            tx_act_r <= 1'b0; // line keeps bit 7
            tx_end_flag_r <= 1'b1;
          end
        end
      end else if (tx_act_r && !cm && tick16) begin
        tovs_r <= tovs_r + 4'h1;
        if (tovs_r == `OVS_LAST) begin
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            if (next_ld_r && !tx_empty_flag_r) begin
              tsr_r <= frame;
              left_r <= nbits;
              tx_empty_flag_r <= 1'b1;
              txd_out <= 1'b0;
            end else begin
              tx_act_r <= 1'b0;
              txd_out <= 1'b1;
              tx_end_flag_r <= tx_end_flag_r | tx_empty_flag_r;
            end
          end else begin
            tsr_r <= {1'b1, tsr_r[11:1]};
            txd_out <= tsr_r[1];
            if (left_r == 4'h2) begin
              next_ld_r <= !tx_empty_flag_r;
              tx_end_flag_r <= tx_empty_flag_r;
            end
          end
        end
      end
    end
  end

  // receive alignment: n bits collected at the top of the buffer
  assign rn = (mode_r[`MODE_SEVEN] ? 4'h7 : 4'h8) + {3'h0, mode_r[`MODE_MP]};
  assign al = rbuf_r >> (4'h9 - rn);
  assign rdat = mode_r[`MODE_SEVEN] ? {1'b0, al[6:0]} : al[7:0];
  assign rmp = mode_r[`MODE_SEVEN] ? al[7] : al[8];

  // receiver; disabling it leaves flags and data untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_r <= serial_comm_unit_pkg::arx_idle;
      rovs_r <= 4'h0;
      rcnt_r <= 4'h0;
      rbuf_r <= 9'h000;
      rdr_r <= 8'h00;
      rx_full_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      fer_r <= 1'b0;
      per_r <= 1'b0;
      mpb_r <= 1'b0;
    end else begin
      if (wr_st && !hwdata[`ST_RX_FULL_FLAG]) begin
        rx_full_flag_r <= 1'b0;
      end
      if (wr_st && !hwdata[`ST_OVERRUN_FLAG]) begin
        overrun_flag_r <= 1'b0;
      end
      if (wr_st && !hwdata[`ST_FER]) begin
        fer_r <= 1'b0;
      end
      if (wr_st && !hwdata[`ST_PER]) begin
        per_r <= 1'b0;
      end
      if (!re || err) begin
        rst_r <= serial_comm_unit_pkg::arx_idle;
        rcnt_r <= 4'h0;
      end else if (cm) begin
        if (rise_ev) begin
          rbuf_r <= {s_rx, rbuf_r[8:1]};
          rcnt_r <= rcnt_r + 4'h1;
          if (rcnt_r == 4'h7) begin
            rcnt_r <= 4'h0;
            if (rx_full_flag_r) begin
              overrun_flag_r <= 1'b1;
            end else begin
              rdr_r <= {s_rx, rbuf_r[8:2]};
              rx_full_flag_r <= 1'b1;
            end
          end
        end
      end else if (tick16) begin
        rovs_r <= rovs_r + 4'h1;
        case (rst_r)
          serial_comm_unit_pkg::arx_idle: begin
            rovs_r <= 4'h0;
            if (!s_rx) begin
              rst_r <= serial_comm_unit_pkg::arx_start;
            end
          end
          serial_comm_unit_pkg::arx_start: begin
            if (rovs_r == `OVS_MID - 4'h1) begin
              rovs_r <= 4'h0;
              rcnt_r <= 4'h0;
              rst_r <= s_rx ? serial_comm_unit_pkg::arx_idle : serial_comm_unit_pkg::arx_data;
            end
          end
          serial_comm_unit_pkg::arx_data: begin
            if (rovs_r == `OVS_LAST) begin
              rbuf_r <= {s_rx, rbuf_r[8:1]};
              rcnt_r <= rcnt_r + 4'h1;
              if (rcnt_r + 4'h1 == rn) begin
                rst_r <= serial_comm_unit_pkg::arx_stop;
              end
            end
          end
          serial_comm_unit_pkg::arx_stop: begin
            if (rovs_r == `OVS_LAST) begin
              rst_r <= serial_comm_unit_pkg::arx_idle;
              if (!(mode_r[`MODE_MP] && ctl_r[`CTL_MP_WAIT] && !rmp)) begin
                mpb_r <= mode_r[`MODE_MP] & rmp;
                if (rx_full_flag_r) begin
                  overrun_flag_r <= 1'b1;
                end else begin
                  rdr_r <= rdat;
                  fer_r <= !s_rx;
                  rx_full_flag_r <= s_rx;
                end
              end
            end
          end
          default: begin
            rst_r <= serial_comm_unit_pkg::arx_idle;
          end
        endcase
      end
    end
  end

  // pin drive and interrupt requests, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_oe_n <= 1'b1;
      sck_out <= 1'b1;
      sck_oe_n <= 1'b1;
      tx_empty_irq <= 1'b0;
      tx_end_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      txd_oe_n <= !te; // port bits take over the pin when te is off
      sck_out <= sck_r;
      sck_oe_n <= !(cm && !ext_clk && (te || re));
      tx_empty_irq <= ctl_r[`CTL_TIE] & tx_empty_flag_r & te;
      tx_end_irq <= ctl_r[`CTL_TX_END_IRQ_ENABLE] & tx_end_flag_r & te;
      rx_full_irq <= ctl_r[`CTL_RIE] & rx_full_flag_r;
      rx_error_irq <= ctl_r[`CTL_RIE] & err;
    end
  end
endmodule : serial_comm_unit
`default_nettype wire

// File: testbench/serial_comm_unit_checker.sv
/*
  port checker of the serial communication unit, bound to its top module.
  assumes one clock domain, hclk, with hresetn as its reset.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_comm_unit_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // serial pins
  input wire logic txd_out,
  input wire logic txd_oe_n,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  // interrupt requests
  input wire logic tx_end_irq,
  input wire logic rx_full_irq
);
  logic req_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // last cycle held an address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= 1'b0;
    end else begin
      req_r <= hsel & htrans[1] & hready;
    end
  end
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_idle_zero: assert property (!req_r |-> hrdata == 32'h0)
    else $error("hrdata not zero in idle cycle");
  a_sck_idle_high: assert property (sck_oe_n |-> sck_out)
    else $error("sck low while not driven");
  a_sck_low_bounded: assert property ($fell(sck_out) |-> ##[1:256] sck_out)
    else $error("sck low phase too long");
  a_txd_idle_mark: assert property (txd_oe_n |-> txd_out)
    else $error("txd low while transmitter off");
  // internal clock: data moves only with a falling serial clock edge;
  // sck_out has one more register stage than txd_out, so the fall follows
  a_txd_on_fall: assert property (!sck_oe_n && !txd_oe_n && !$past(sck_oe_n) &&
    !$past(txd_oe_n) && !$stable(txd_out) |=> $fell(sck_out))
    else $error("txd changed without sck fall");
  a_txd_end_hold: assert property ($rose(tx_end_irq) && !sck_oe_n |->
    $stable(txd_out)[*4]) else $error("txd moved after end of transmit");
  c_sck_fall: cover property ($fell(sck_out));
  c_rx_full: cover property ($rose(rx_full_irq));
  c_tx_end: cover property ($rose(tx_end_irq));
endmodule : serial_comm_unit_checker
bind serial_comm_unit serial_comm_unit_checker u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hready, .hrdata, .hreadyout, .hresp, .txd_out, .txd_oe_n, .sck_out, .sck_oe_n,
  .tx_end_irq, .rx_full_irq);
`default_nettype wire

// File: testbench/serial_peer_model.sv
/*
  far-side serial peer for clocked mode: drives rxd on each falling serial
  clock edge, captures txd on each rising edge, and can make the external clock.
  assumes the bench calls arm before each frame it wants to check.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_peer_model (
  // from the unit
  input wire logic txd_out,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  // to the unit
  output logic rxd_in,
  output logic sck_in
);
  logic [7:0] tx_b = 8'h00;
  logic [7:0] got = 8'h00;
  int idx = 8;
  int rises = 0;
  wire logic sck = sck_oe_n ? sck_in : sck_out;
  initial begin
    rxd_in = 1'b1;
    sck_in = 1'b1;
  end
  task automatic arm(input logic [7:0] b);
    tx_b = b;
    idx = 0;
    got = 8'h00;
    rises = 0;
    rxd_in = ~b[0];
  endtask : arm
  // external clock stands high outside frames
  task automatic ext_clk8();
    repeat (8) begin
      sck_in = 1'b0;
      #24;
      sck_in = 1'b1;
      #24;
    end
  endtask : ext_clk8
  // after the byte the line is released: toggles so stale data never matches
  always @(negedge sck) begin
    rxd_in <= (idx < 8) ? tx_b[idx[2:0]] : ~rxd_in;
    idx <= idx + 1;
  end
  always @(posedge sck) begin
    got <= {txd_out, got[7:1]};
    rises <= rises + 1;
  end
endmodule : serial_peer_model
`default_nettype wire

// File: testbench/serial_comm_unit_tb.sv
/*
  self-checking bench of the serial communication unit: clocked transmit,
  receive with overrun, external clock and multiprocessor framing.
  assumes the register header on the include path and a single bus master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_comm_unit_regs.svh"
module serial_comm_unit_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, rxd_in, txd_out, txd_oe_n, sck_in, sck_out, sck_oe_n;
  logic tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
  logic [21:0] bits;
  int fails = 0;
  int n_checks = 0;
  always #2 hclk = ~hclk;
  serial_comm_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd_in, .txd_out, .txd_oe_n, .sck_in,
    .sck_out, .sck_oe_n, .tx_empty_irq, .tx_end_irq, .rx_full_irq, .rx_error_irq);
  serial_peer_model peer (.txd_out, .sck_out, .sck_oe_n, .rxd_in, .sck_in);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic give_up();
    fails++;
    stop_test();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) give_up();
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rchk
  // polls a status bit; reads are cheap against the frame length
  task automatic wait_st(input int b);
    int n;
    n = 0;
    bus(1'b0, `OFS_STATUS, 8'h00);
    while (rd[b] !== 1'b1) begin
      n++;
      if (n > 400) give_up();
      bus(1'b0, `OFS_STATUS, 8'h00);
    end
  endtask : wait_st
  task automatic get_bits();
    int n;
    n = 0;
    @(posedge hclk);
    while (txd_out !== 1'b0) begin
      n++;
      if (n > 300) give_up();
      @(posedge hclk);
    end
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 22; i++) begin
      bits[i] = txd_out;
      repeat (16) @(posedge hclk);
    end
  endtask : get_bits
  task automatic t_reset();
    rchk(`OFS_STATUS, 8'h84);
    rchk(`OFS_MODE, 8'h00);
    rchk(`OFS_BITRATE, 8'h05);
    rchk(8'h40, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_clk_tx();
    wr(`OFS_MODE, 8'h01);
    wr(`OFS_CONTROL, 8'h11);
    peer.arm(8'h00);
    wr(`OFS_TXDATA, 8'h5a);
    wr(`OFS_STATUS, 8'h7e);
    rchk(`OFS_STATUS, 8'h80);
    wr(`OFS_TXDATA, 8'h3c);
    wr(`OFS_STATUS, 8'h7e);
    wait_st(`ST_TX_END_FLAG);
    // tx_end_flag rises at the last fall; the last rise follows a half period later
    repeat (20) @(posedge hclk);
    chk(peer.rises, 16);
    chk(peer.got, 8'h3c);
    chk(txd_out, 1'b0);
    chk(tx_end_irq, 1'b1);
    $display("test clocked transmit done");
  endtask : t_clk_tx
  task automatic t_clk_rx();
    wr(`OFS_CONTROL, 8'h00);
    peer.arm(8'hc3);
    wr(`OFS_CONTROL, 8'h0a);
    wait_st(`ST_OVERRUN_FLAG);
    rchk(`OFS_RXDATA, 8'hc3);
    rchk(`OFS_STATUS, 8'he4);
    chk(rx_full_irq, 1'b1);
    chk(rx_error_irq, 1'b1);
    peer.arm(8'h00);
    wr(`OFS_CONTROL, 8'h0b);
    wr(`OFS_TXDATA, 8'h11);
    wr(`OFS_STATUS, 8'h7e);
    repeat (100) @(posedge hclk);
    chk(peer.rises, 0);
    wr(`OFS_CONTROL, 8'h00);
    rchk(`OFS_STATUS, 8'he4);
    rchk(`OFS_RXDATA, 8'hc3);
    wr(`OFS_STATUS, 8'h80);
    $display("test clocked receive done");
  endtask : t_clk_rx
  task automatic t_ext();
    wr(`OFS_CONTROL, 8'h40);
    peer.arm(8'h00);
    wr(`OFS_CONTROL, 8'h41);
    wr(`OFS_TXDATA, 8'h96);
    wr(`OFS_STATUS, 8'h7e);
    repeat (6) @(posedge hclk);
    #7;
    peer.ext_clk8();
    repeat (6) @(posedge hclk);
    chk(peer.got, 8'h96);
    chk(sck_oe_n, 1'b1);
    wait_st(`ST_TX_END_FLAG);
    $display("test external clock done");
  endtask : t_ext
  task automatic t_mp();
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_MODE, 8'h08);
    wr(`OFS_BITRATE, 8'h00);
    wr(`OFS_CONTROL, 8'h05);
    wr(`OFS_TXDATA, 8'hb4);
    fork
      get_bits();
      begin
        wr(`OFS_STATUS, 8'h7f);
        wr(`OFS_TXDATA, 8'h2d);
        chk(tx_empty_irq, 1'b1);
        wr(`OFS_STATUS, 8'h7e);
      end
    join
    chk(bits, {1'b1, 1'b0, 8'h2d, 1'b0, 1'b1, 1'b1, 8'hb4, 1'b0});
    repeat (40) @(posedge hclk);
    chk(txd_out, 1'b1);
    rchk(`OFS_STATUS, 8'h84);
    wr(`OFS_CONTROL, 8'h00);
    repeat (2) @(posedge hclk);
    chk(txd_oe_n, 1'b1);
    $display("test multiprocessor transmit done");
  endtask : t_mp
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_clk_tx();
    t_clk_rx();
    t_ext();
    t_mp();
    stop_test();
  end
endmodule : serial_comm_unit_tb
`default_nettype wire
